// *** hdl/vfpa_pkg.sv ***
// Package of constants for the frame pulse alignment block
package vfpa_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_RATIO_LO = 8'h09;
  localparam logic [7:0] ADDR_RATIO_HI = 8'h0a;
  localparam logic [7:0] ADDR_PPL_LO = 8'h0b;
  localparam logic [7:0] ADDR_PPL_HI = 8'h0c;
  localparam logic [7:0] ADDR_OLPF_LO = 8'h0d;
  localparam logic [7:0] ADDR_OLPF_HI = 8'h0e;
  localparam logic [7:0] ADDR_RLPF_LO = 8'h0f;
  localparam logic [7:0] ADDR_RLPF_HI = 8'h10;
  localparam logic [7:0] ADDR_OFS_LO = 8'h11;
  localparam logic [7:0] ADDR_OFS_HI = 8'h12;
  // Field positions
  localparam int BIT_REF_VALID = 0;
  localparam int BIT_SD_LOOP_LOCKED = 1;
  localparam int BIT_HD_LOOP_LOCKED = 2;
  localparam int BIT_FLOAT = 7;
  localparam int BIT_ALIGN_EN = 7;
  localparam int BIT_INIT = 6;
  localparam int BIT_CLK_SEL = 7;
  localparam int BIT_REDUCED = 6;
  // Reset values: 2002 pixels, 225 lines, offset equal to lines
  localparam logic [12:0] PPL_RST = 13'h07d2;
  localparam logic [12:0] OLPF_RST = 13'h00e1;
  localparam logic [12:0] RLPF_RST = 13'h00e1;
  localparam logic [12:0] OFS_RST = 13'h00e1;
  localparam logic [12:0] RATIO_RST = 13'h0001;
  localparam logic [12:0] CNT_ONE = 13'h0001;
  localparam logic [2:0] STEP_REDUCED = 3'h5;
  // Alignment sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ALIGN} vfpa_state_e;
endpackage

// *** hdl/vfpa_top.sv ***
// Frame pulse generator with reference alignment and status flags
`timescale 1ns/100ps
module vfpa_top #(
  parameter int CW = 13
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Output clock strobes, one cycle per tick
  input wire logic sd_output_clock_tick,
  input wire logic hd_output_clock_tick,
  // Reference timing
  input wire logic ref_line_tick,
  input wire logic ref_frame_start,
  // Detector inputs
  input wire logic hsync_format_ok,
  input wire logic dividers_ok,
  input wire logic vcxo_in_range,
  input wire logic sd_loop_locked,
  input wire logic hd_loop_locked,
  // Outputs
  output logic frame_pulse_o,
  output logic frame_pulse_oe,
  output logic no_ref_flag,
  output logic no_lock_flag,
  output logic counter_reset
);
  //----------------------------------------
  // Registers
  //----------------------------------------
  logic [7:0] out_ctrl_q; // Float bit; other bits are stored and read back only
  logic [CW-1:0] ratio_q; // Frame ratio numerator
  logic align_en_q; // Alignment enable
  logic init_q; // Counter initialize bit
  logic clk_sel_q; // Pulse clock select
  logic reduced_q; // Reduced divider set
  logic [CW-1:0] ppl_q; // Pixels per line
  logic [CW-1:0] olpf_q; // Output lines per frame
  logic [CW-1:0] rlpf_q; // Reference lines per frame
  logic [CW-1:0] ofs_q; // Line offset
  logic init_prev_q; // Previous init for edge
  logic init_rise; // Init rising edge
  logic ref_valid; // Reference valid status
  logic [7:0] status; // Status byte
  // Register writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_ctrl_q <= 8'h00;
      ratio_q <= vfpa_pkg::RATIO_RST;
      align_en_q <= 1'b0;
      init_q <= 1'b0;
      clk_sel_q <= 1'b0;
      reduced_q <= 1'b0;
      ppl_q <= vfpa_pkg::PPL_RST;
      olpf_q <= vfpa_pkg::OLPF_RST;
      rlpf_q <= vfpa_pkg::RLPF_RST;
      ofs_q <= vfpa_pkg::OFS_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        vfpa_pkg::ADDR_OUT_CTRL: out_ctrl_q <= reg_wdata;
        vfpa_pkg::ADDR_RATIO_LO: ratio_q[7:0] <= reg_wdata;
        vfpa_pkg::ADDR_RATIO_HI: begin
          ratio_q[CW-1:8] <= reg_wdata[CW-9:0];
          align_en_q <= reg_wdata[vfpa_pkg::BIT_ALIGN_EN];
          init_q <= reg_wdata[vfpa_pkg::BIT_INIT];
        end
        vfpa_pkg::ADDR_PPL_LO: ppl_q[7:0] <= reg_wdata;
        vfpa_pkg::ADDR_PPL_HI: begin
          ppl_q[CW-1:8] <= reg_wdata[CW-9:0];
          clk_sel_q <= reg_wdata[vfpa_pkg::BIT_CLK_SEL];
        end
        vfpa_pkg::ADDR_OLPF_LO: olpf_q[7:0] <= reg_wdata;
        vfpa_pkg::ADDR_OLPF_HI: olpf_q[CW-1:8] <= reg_wdata[CW-9:0];
        vfpa_pkg::ADDR_RLPF_LO: rlpf_q[7:0] <= reg_wdata;
        vfpa_pkg::ADDR_RLPF_HI: begin
          rlpf_q[CW-1:8] <= reg_wdata[CW-9:0];
          reduced_q <= reg_wdata[vfpa_pkg::BIT_REDUCED];
        end
        vfpa_pkg::ADDR_OFS_LO: ofs_q[7:0] <= reg_wdata;
        vfpa_pkg::ADDR_OFS_HI: ofs_q[CW-1:8] <= reg_wdata[CW-9:0];
        default: ;
      endcase
    end
  end
  //----------------------------------------
  // Status and flags
  //----------------------------------------
  // Validity ignores V sync entirely
  assign ref_valid = hsync_format_ok & dividers_ok & vcxo_in_range;
  assign status = {5'h00, hd_loop_locked, sd_loop_locked, ref_valid};
  // Read mux
  always_comb begin
    unique case (reg_addr)
      vfpa_pkg::ADDR_STATUS: reg_rdata = status;
      vfpa_pkg::ADDR_OUT_CTRL: reg_rdata = out_ctrl_q;
      vfpa_pkg::ADDR_RATIO_LO: reg_rdata = ratio_q[7:0];
      vfpa_pkg::ADDR_RATIO_HI:
        reg_rdata = {align_en_q, init_q, 1'b0, ratio_q[CW-1:8]};
      vfpa_pkg::ADDR_PPL_LO: reg_rdata = ppl_q[7:0];
      vfpa_pkg::ADDR_PPL_HI: reg_rdata = {clk_sel_q, 2'b00, ppl_q[CW-1:8]};
      vfpa_pkg::ADDR_OLPF_LO: reg_rdata = olpf_q[7:0];
      vfpa_pkg::ADDR_OLPF_HI: reg_rdata = {3'b000, olpf_q[CW-1:8]};
      vfpa_pkg::ADDR_RLPF_LO: reg_rdata = rlpf_q[7:0];
      vfpa_pkg::ADDR_RLPF_HI: reg_rdata = {1'b0, reduced_q, 1'b0, rlpf_q[CW-1:8]};
      vfpa_pkg::ADDR_OFS_LO: reg_rdata = ofs_q[7:0];
      vfpa_pkg::ADDR_OFS_HI: reg_rdata = {3'b000, ofs_q[CW-1:8]};
      default: reg_rdata = 8'h00;
    endcase
  end
  // Flag pins registered from status
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      no_ref_flag <= 1'b1;
      no_lock_flag <= 1'b1;
    end else begin
      no_ref_flag <= ~ref_valid;
      no_lock_flag <= ~(ref_valid & sd_loop_locked & hd_loop_locked);
    end
  end
  //----------------------------------------
  // Initialize edge and alignment sequence
  //----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) init_prev_q <= 1'b0;
    else init_prev_q <= init_q;
  end
  assign init_rise = init_q & ~init_prev_q;
  vfpa_pkg::vfpa_state_e state_q;
  logic [CW-1:0] ref_line_q; // Reference line counter
  logic [CW-1:0] ratio_cnt_q; // Reference frames per output frame
  logic [CW-1:0] target_q; // Offset in reference lines
  logic align_hit; // Aligned line reached
  logic pix_tick; // Selected counting clock tick
  logic [CW-1:0] pix_q; // Pixel counter
  logic [CW-1:0] line_q; // Line counter
  logic line_wrap; // End of line
  logic frame_wrap; // End of frame
  // Offset scaled by five for the reduced divider set
  always_ff @(posedge ref_clk) begin
    if (srst) target_q <= vfpa_pkg::OFS_RST;
    else if (reduced_q) target_q <= CW'(ofs_q * vfpa_pkg::STEP_REDUCED);
    else target_q <= ofs_q;
  end
  // Internal reference line count, restarted by decoded frame start
  always_ff @(posedge ref_clk) begin
    if (srst) ref_line_q <= '0;
    else if (ref_frame_start) ref_line_q <= vfpa_pkg::CNT_ONE;
    else if (ref_line_tick)
      ref_line_q <= (ref_line_q >= rlpf_q) ? vfpa_pkg::CNT_ONE : ref_line_q + 1'b1;
  end
  // Reference frames counted against the ratio numerator
  always_ff @(posedge ref_clk) begin
    if (srst || init_rise) ratio_cnt_q <= '0;
    else if (ref_frame_start)
      ratio_cnt_q <= (ratio_cnt_q + 1'b1 >= ratio_q) ? '0 : ratio_cnt_q + 1'b1;
  end
  assign align_hit = ref_line_tick && (ref_line_q == target_q) && (ratio_cnt_q == '0);
  // Sequencer: armed by init edge, realigns once every ratio_q reference frames while enabled
  always_ff @(posedge ref_clk) begin
    if (srst) state_q <= vfpa_pkg::ST_IDLE;
    else begin
      unique case (state_q)
        vfpa_pkg::ST_IDLE:
          if (align_en_q && init_rise) state_q <= vfpa_pkg::ST_ARMED;
        vfpa_pkg::ST_ARMED:
          if (!align_en_q) state_q <= vfpa_pkg::ST_IDLE;
          else if (align_hit) state_q <= vfpa_pkg::ST_ALIGN;
        vfpa_pkg::ST_ALIGN:
          state_q <= align_en_q ? vfpa_pkg::ST_ARMED : vfpa_pkg::ST_IDLE;
      endcase
    end
  end
  assign counter_reset = (state_q == vfpa_pkg::ST_ALIGN) || init_rise;
  //----------------------------------------
  // Pulse counter chain
  //----------------------------------------
  assign pix_tick = clk_sel_q ? hd_output_clock_tick : sd_output_clock_tick;
  assign line_wrap = pix_q >= ppl_q - 1'b1;
  assign frame_wrap = line_q >= olpf_q - 1'b1;
  // Free-running chain keeps going without reference
  always_ff @(posedge ref_clk) begin
    if (srst || counter_reset) begin
      pix_q <= '0;
      line_q <= '0;
    end else if (pix_tick) begin
      pix_q <= line_wrap ? '0 : pix_q + 1'b1;
      if (line_wrap) line_q <= frame_wrap ? '0 : line_q + 1'b1;
    end
  end
  // Pulse high for first line of frame; enable is the inverse of the float bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      frame_pulse_o <= 1'b0;
      frame_pulse_oe <= 1'b0;
    end else begin
      frame_pulse_o <= (line_q == '0);
      frame_pulse_oe <= ~out_ctrl_q[vfpa_pkg::BIT_FLOAT];
    end
  end
  //----------------------------------------
  // Assertions
  //----------------------------------------
  // Reference flag pin tracks the status one cycle late
  a_noref_flag: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 no_ref_flag == !$past(ref_valid)) else $error("no-ref flag wrong");
  // Lock flag clears only with all three status bits
  a_nolock_flag: assert property (@(posedge ref_clk) disable iff (srst)
    (ref_valid && sd_loop_locked && hd_loop_locked) |=> !no_lock_flag)
    else $error("no-lock flag wrong");
  // Any missing status bit raises the lock flag
  a_nolock_set: assert property (@(posedge ref_clk) disable iff (srst)
    !(ref_valid && sd_loop_locked && hd_loop_locked) |=> no_lock_flag)
    else $error("no-lock flag low");
  // Missing reference raises the reference flag
  a_noref_set: assert property (@(posedge ref_clk) disable iff (srst)
    !ref_valid |=> no_ref_flag)
    else $error("no-ref flag low");
  // Held initialize bit never restarts the chain
  a_init_edge: assert property (@(posedge ref_clk) disable iff (srst)
    (init_q && $past(init_q) && state_q != vfpa_pkg::ST_ALIGN) |-> !counter_reset)
    else $error("held init reset counters");
  // Armed sequencer meeting the target line
  sequence s_armed_hit;
    state_q == vfpa_pkg::ST_ARMED && align_en_q && align_hit;
  endsequence
  // Initialize bit seen low, then high
  sequence s_init_edge;
    !init_q ##1 init_q;
  endsequence
  // Target line hit resets the chain next cycle
  a_align_go: assert property (@(posedge ref_clk) disable iff (srst)
    s_armed_hit |=> counter_reset ##1 (pix_q == '0)) else $error("no alignment");
  // Fresh initialize edge resets the chain at once
  a_init_go: assert property (@(posedge ref_clk) disable iff (srst)
    s_init_edge |-> counter_reset ##1 (pix_q == '0 && line_q == '0))
    else $error("init edge ignored");
  // Enable held keeps the sequencer armed
  a_realign: assert property (@(posedge ref_clk) disable iff (srst)
    (state_q == vfpa_pkg::ST_ALIGN && align_en_q) |=> state_q == vfpa_pkg::ST_ARMED)
    else $error("no realign arm");
  // Cleared enable drops the armed sequencer
  a_arm_leave: assert property (@(posedge ref_clk) disable iff (srst)
    (state_q == vfpa_pkg::ST_ARMED && !align_en_q) |=> state_q == vfpa_pkg::ST_IDLE)
    else $error("still armed");
  // Idle sequencer leaves the chain alone
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    (state_q == vfpa_pkg::ST_IDLE && !init_rise) |-> !counter_reset)
    else $error("reset while idle");
  // Decoded frame start restarts the reference line count
  a_ref_restart: assert property (@(posedge ref_clk) disable iff (srst)
    ref_frame_start |=> ref_line_q == vfpa_pkg::CNT_ONE)
    else $error("reference line not restarted");
  // Plain divider set uses the offset as it is
  a_offset_plain: assert property (@(posedge ref_clk) disable iff (srst)
    (!reduced_q && $stable(ofs_q)) |=> target_q == $past(ofs_q))
    else $error("bad offset");
  // Reduced divider set steps five lines per unit
  a_reduced_step: assert property (@(posedge ref_clk) disable iff (srst)
    (reduced_q && $stable(ofs_q)) |=> target_q == CW'($past(ofs_q) * vfpa_pkg::STEP_REDUCED))
    else $error("bad step");
  //----------------------------------------
  // Assertions on the pulse chain, pins and status read
  //----------------------------------------
  // Only SD strobes count while SD is selected
  a_clk_select: assert property (@(posedge ref_clk) disable iff (srst)
    (!counter_reset && !clk_sel_q && !sd_output_clock_tick) |=> $stable(pix_q))
    else $error("wrong clock counted");
  // Only HD strobes count while HD is selected
  a_hd_select: assert property (@(posedge ref_clk) disable iff (srst)
    (!counter_reset && clk_sel_q && !hd_output_clock_tick) |=> $stable(pix_q))
    else $error("wrong clock counted");
  // Chain advances by one per tick, reference or not
  a_free_run: assert property (@(posedge ref_clk) disable iff (srst)
    (!counter_reset && pix_tick && !line_wrap) |=> pix_q == $past(pix_q) + 1'b1)
    else $error("chain stalled");
  // Pixel count wraps at the line length
  a_pixel_wrap: assert property (@(posedge ref_clk) disable iff (srst)
    (!counter_reset && pix_tick && line_wrap) |=> pix_q == '0) else $error("no wrap");
  // Line count wraps at the frame length
  a_line_wrap: assert property (@(posedge ref_clk) disable iff (srst)
    (!counter_reset && pix_tick && line_wrap && frame_wrap) |=> line_q == '0)
    else $error("no line wrap");
  // Pulse follows the first line of the frame
  a_pulse_line: assert property (@(posedge ref_clk) disable iff (srst)
    (line_q == '0) |=> frame_pulse_o)
    else $error("pulse missing");
  // Float bit releases the pin
  a_float_pin: assert property (@(posedge ref_clk) disable iff (srst)
    out_ctrl_q[vfpa_pkg::BIT_FLOAT] |=> !frame_pulse_oe) else $error("pin driven");
  // Cleared float bit drives the pin
  a_drive_pin: assert property (@(posedge ref_clk) disable iff (srst)
    !out_ctrl_q[vfpa_pkg::BIT_FLOAT] |=> frame_pulse_oe)
    else $error("pin floated");
  // Status bits sit at their field positions
  a_status_bits: assert property (@(posedge ref_clk) disable iff (srst)
    (reg_addr == vfpa_pkg::ADDR_STATUS) |->
      (reg_rdata[vfpa_pkg::BIT_REF_VALID] == ref_valid &&
       reg_rdata[vfpa_pkg::BIT_SD_LOOP_LOCKED] == sd_loop_locked &&
       reg_rdata[vfpa_pkg::BIT_HD_LOOP_LOCKED] == hd_loop_locked))
    else $error("status bits misplaced");
endmodule

// *** bench/vfpa_ref_model.sv ***
// Reference sync source and output clock strobes for the bench
`timescale 1ns/100ps
module vfpa_ref_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Reference present
  input wire logic run,
  // Strobes
  output logic sd_output_clock_tick,
  output logic hd_output_clock_tick,
  output logic ref_line_tick,
  output logic ref_frame_start
);
  logic [3:0] cnt_q; // Cycle count in one reference frame
  // ----------------------------------------
  // Strobes
  // ----------------------------------------
  // Free cycle counter, frame of 4 lines of 4 cycles
  always_ff @(posedge ref_clk) begin
    cnt_q <= srst ? 4'h0 : cnt_q + 4'h1;
  end
  // Sync strobes vanish while the reference is lost
  always_comb begin
    sd_output_clock_tick = 1'b1;
    hd_output_clock_tick = cnt_q[0];
    ref_line_tick = run && (cnt_q[1:0] == 2'h0);
    ref_frame_start = run && (cnt_q == 4'h0);
  end
endmodule

// *** bench/vfpa_top_bench.sv ***
// Self-checking bench of the frame pulse alignment block
`timescale 1ns/100ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t %s", $time, m); end end
module vfpa_top_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk = 1'b0; // Bench clock
  logic srst; // Sync reset
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, run, v;
  logic sd_output_clock_tick, hd_output_clock_tick, ref_line_tick, ref_frame_start;
  logic [4:0] det; // Detector levels
  logic frame_pulse_o, frame_pulse_oe, no_ref_flag, no_lock_flag, counter_reset;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int fp_n, cr_n; // Tallies of pulse and reset cycles
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  vfpa_top i_vfpa_top (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .sd_output_clock_tick, .hd_output_clock_tick, .ref_line_tick, .ref_frame_start,
    .hsync_format_ok(det[4]), .dividers_ok(det[3]), .vcxo_in_range(det[2]),
    .sd_loop_locked(det[1]), .hd_loop_locked(det[0]), .frame_pulse_o,
    .frame_pulse_oe, .no_ref_flag, .no_lock_flag, .counter_reset);
  vfpa_ref_model i_vfpa_ref_model (.ref_clk, .srst, .run, .sd_output_clock_tick,
    .hd_output_clock_tick, .ref_line_tick, .ref_frame_start);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Closing report
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Register read and compare
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    @(posedge ref_clk);
    #1;
    `CHK(reg_rdata, e, "read data")
  endtask
  // Count pulse and reset cycles over n cycles
  task automatic tally(input int n);
    fp_n = 0;
    cr_n = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      fp_n += (frame_pulse_o === 1'b1);
      cr_n += (counter_reset === 1'b1);
    end
  endtask
  // Wait a bounded time for a counter reset
  task automatic wait_cr();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (counter_reset !== 1'b1 && k < 40);
    `CHK(counter_reset, 1'b1, "no counter reset")
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    det = 5'h00;
    run = 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    // Reset values, unmapped and read-only places
    rd(vfpa_pkg::ADDR_PPL_LO, 8'hd2);
    rd(vfpa_pkg::ADDR_PPL_HI, 8'h07);
    rd(vfpa_pkg::ADDR_OLPF_LO, 8'he1);
    rd(vfpa_pkg::ADDR_OFS_LO, 8'he1);
    rd(8'h20, 8'h00);
    wr(vfpa_pkg::ADDR_RLPF_HI, 8'h40);
    rd(vfpa_pkg::ADDR_RLPF_HI, 8'h40);
    wr(vfpa_pkg::ADDR_STATUS, 8'hff);
    rd(vfpa_pkg::ADDR_STATUS, 8'h00);
    $display("test registers done");
    // Every detector combination against both flags
    for (int i = 0; i < 32; i++) begin
      @(posedge ref_clk);
      det <= i[4:0];
      @(posedge ref_clk);
      #1;
      v = det[4] & det[3] & det[2];
      `CHK(no_ref_flag, ~v, "ref flag")
      `CHK(no_lock_flag, ~(v & det[1] & det[0]), "lock flag")
    end
    rd(vfpa_pkg::ADDR_STATUS, 8'h07);
    $display("test flags done");
    // Output float bit
    wr(vfpa_pkg::ADDR_OUT_CTRL, 8'h80);
    tally(2);
    `CHK(frame_pulse_oe, 1'b0, "pulse not floated")
    wr(vfpa_pkg::ADDR_OUT_CTRL, 8'h00);
    tally(2);
    `CHK(frame_pulse_oe, 1'b1, "pulse not driven")
    $display("test float done");
    // Short frame of 8 pixels by 4 lines, reference 4 lines, offset 2
    wr(vfpa_pkg::ADDR_PPL_LO, 8'h08);
    wr(vfpa_pkg::ADDR_PPL_HI, 8'h00);
    wr(vfpa_pkg::ADDR_OLPF_LO, 8'h04);
    wr(vfpa_pkg::ADDR_OLPF_HI, 8'h00);
    wr(vfpa_pkg::ADDR_RLPF_LO, 8'h04);
    wr(vfpa_pkg::ADDR_RLPF_HI, 8'h00);
    wr(vfpa_pkg::ADDR_OFS_LO, 8'h02);
    wr(vfpa_pkg::ADDR_OFS_HI, 8'h00);
    wr(vfpa_pkg::ADDR_RATIO_LO, 8'h01);
    wr(vfpa_pkg::ADDR_RATIO_HI, 8'h80);
    wr(vfpa_pkg::ADDR_RATIO_HI, 8'hc0);
    #1;
    `CHK(counter_reset, 1'b1, "no init reset")
    wait_cr();
    tally(2);
    wait_cr();
    tally(3);
    `CHK(fp_n > 0, 1'b1, "pulse not aligned")
    wr(vfpa_pkg::ADDR_RATIO_HI, 8'h00);
    tally(100);
    `CHK(cr_n, 0, "reset without enable")
    wr(vfpa_pkg::ADDR_RATIO_HI, 8'h40);
    #1;
    `CHK(counter_reset, 1'b1, "init edge ignored")
    tally(100);
    `CHK(cr_n, 0, "init level retriggers")
    wr(vfpa_pkg::ADDR_RATIO_HI, 8'h00);
    $display("test alignment done");
    // Reference lost: pulse keeps its count on both clocks
    run <= 1'b0;
    tally(320);
    `CHK(fp_n, 80, "sd pulse count")
    wr(vfpa_pkg::ADDR_PPL_HI, 8'h80);
    tally(64);
    tally(640);
    `CHK(fp_n, 160, "hd pulse count")
    $display("test free run done");
    end_of_test();
  end
endmodule
